// file: flash_host_model.sv
// host controller model for the link side
`default_nettype none
module flash_host_model (
    // link drive
    output logic link_clk,
    output logic link_cs_n,
    output logic rd_start,
    output flash_prot_pkg::read_kind_t rd_kind,
    output logic rd_dtr,
    output logic pe_req,
    output logic [22:0] pe_lo,
    output logic [22:0] pe_hi,
    // link results
    input wire logic data_phase,
    input wire logic pe_accept,
    input wire logic pe_ignore
);
    timeunit 1ns;
    timeprecision 100ps;
    import flash_prot_pkg::*;
    initial begin
        link_clk = 1'b0;
        link_cs_n = 1'b1;
        rd_start = 1'b0;
        rd_kind = rk_fast;
        rd_dtr = 1'b0;
        pe_req = 1'b0;
        pe_lo = 23'h0;
        pe_hi = 23'h0;
    end
    // clock runs only here; drives change on the falling edge
    task automatic tick(input int n);
        repeat (n) begin
            #62.5 link_clk = 1'b1;
            #62.5 link_clk = 1'b0;
        end
    endtask
    task automatic close();
        link_cs_n <= 1'b1;
        pe_lo <= ~pe_lo;
        pe_hi <= ~pe_hi;
        tick(2);
    endtask
    // idle frame so settings can cross
    task automatic settle();
        link_cs_n <= 1'b0;
        tick(10);
        close();
    endtask
    task automatic read_frame(input read_kind_t k, input logic d,
                              output int n);
        link_cs_n <= 1'b0;
        rd_kind <= k;
        rd_dtr <= d;
        rd_start <= 1'b1;
        tick(1);
        rd_start <= 1'b0;
        n = 0;
        while (data_phase !== 1'b1 && n < 16) begin
            tick(1);
            n++;
        end
    endtask
    task automatic pe_check(input logic [22:0] lo, input logic [22:0] hi,
                            output logic acc, output logic ign);
        link_cs_n <= 1'b0;
        pe_req <= 1'b1;
        pe_lo <= lo;
        pe_hi <= hi;
        tick(1);
        pe_req <= 1'b0;
        acc = pe_accept;
        ign = pe_ignore;
        close();
    endtask
endmodule  // flash_host_model
`default_nettype wire

// file: flash_prot.sv
// dummy clock selection and array protection with avalon register access
//
// Function
// - two-bit selector picks dummy clocks, resets 00
// - str fast/dual/quad output reads: always 8
// - str dual io, quad word: 4,8,4,8
// - str quad io: 6,4,8,10
// - dtr fast, dual io: 6,4,8,10
// - dtr quad io: 8,4,6,10
// - reserved bit writes change nothing
// - level 000 none, 111 whole array
// - block levels 128KB..4MB, top or bottom
// - sector levels 4KB..32KB, top or bottom
// - reject erase/program touching protected range
// - complement inverts the decoded protected region
`include "flash_prot_defs.svh"
`default_nettype none
module flash_prot (
    // system
    input wire logic mclk,
    input wire logic nrst,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // link side, on the serial clock
    input wire logic link_clk,
    input wire logic link_cs_n,
    input wire logic rd_start,
    input wire flash_prot_pkg::read_kind_t rd_kind,
    input wire logic rd_dtr,
    input wire logic pe_req,
    input wire logic [22:0] pe_lo,
    input wire logic [22:0] pe_hi,
    // link side results
    output logic data_phase,
    output logic [3:0] dummy_clocks,
    output logic pe_accept,
    output logic pe_ignore
);
    import flash_prot_pkg::*;

    bus_regs_t m_q;
    bus_regs_t m_d;
    link_regs_t l_q;
    link_regs_t l_d;

    // dummy clocks for a read kind, rate and selector
    function automatic logic [3:0] dummy_for(
        input read_kind_t kind,
        input logic dtr,
        input logic [1:0] sel
    );
        logic [3:0] n;
        n = `DUMMY_8;
        if (dtr && (kind == rk_fast || kind == rk_dual_io)) begin
            case (sel)
                `DC_00: n = `DUMMY_6;
                `DC_01: n = `DUMMY_4;
                `DC_10: n = `DUMMY_8;
                default: n = `DUMMY_10;
            endcase
        end else if (dtr && kind == rk_quad_io) begin
            case (sel)
                `DC_00: n = `DUMMY_8;
                `DC_01: n = `DUMMY_4;
                `DC_10: n = `DUMMY_6;
                default: n = `DUMMY_10;
            endcase
        end else begin
            case (kind)
                rk_fast, rk_dual_out, rk_quad_out: begin
                    n = `DUMMY_8;
                end
                rk_dual_io, rk_quad_word: begin
                    n = (sel[0]) ? `DUMMY_8 : `DUMMY_4;
                end
                rk_quad_io: begin
                    case (sel)
                        `DC_00: n = `DUMMY_6;
                        `DC_01: n = `DUMMY_4;
                        `DC_10: n = `DUMMY_8;
                        default: n = `DUMMY_10;
                    endcase
                end
                default: n = `DUMMY_8;
            endcase
        end
        return n;
    endfunction

    // true when any address of [a,b] is protected
    function automatic logic region_hits(
        input logic [22:0] a,
        input logic [22:0] b,
        input logic [22:0] lo,
        input logic [22:0] hi,
        input logic any,
        input logic cmp
    );
        logic covered;
        logic overlap;
        covered = any && (a >= lo) && (b <= hi);
        overlap = any && (a <= hi) && (b >= lo);
        // complemented: protected is everything outside the range
        return cmp ? !covered : overlap;
    endfunction

    // decoded range from the protect settings
    logic [4:0] shift;
    logic [23:0] size;
    logic [23:0] top_lo;
    logic [23:0] bot_hi;
    logic [22:0] dec_lo;
    logic [22:0] dec_hi;
    logic dec_any;
    logic [2:0] sec_level;

    always_comb begin
        sec_level = (m_q.bp > `SECTOR_LEVEL_MAX) ? `SECTOR_LEVEL_MAX
                                                 : m_q.bp;
        if (m_q.sec) begin
            shift = `SECTOR_SHIFT_BASE + {2'h0, sec_level};
        end else begin
            shift = `BLOCK_SHIFT_BASE + {2'h0, m_q.bp};
        end
        size = 24'h1 << shift;
        top_lo = `ARRAY_SIZE - size;
        bot_hi = size - 24'h1;
        dec_any = (m_q.bp != `BP_NONE);
        if (m_q.bp == `BP_ALL) begin
            dec_lo = '0;
            dec_hi = `ARRAY_LAST;
        end else if (m_q.tb) begin
            dec_lo = '0;
            dec_hi = bot_hi[22:0];
        end else begin
            dec_lo = top_lo[22:0];
            dec_hi = `ARRAY_LAST;
        end
    end

    // register bus side
    logic pending;
    logic [31:0] rd_mux;
    logic [22:0] zero_addr;
    // settings as decoded here and as last handed to the link
    logic [49:0] live_word;
    logic [49:0] sent_word;

    always_comb begin
        m_d = m_q;
        zero_addr = '0;
        pending = m_q.req_tgl ^ m_q.ack_sync;
        rd_mux = '0;
        case (avs_address)
            `REG_CFG: begin
                // reserved bits read as zero
                rd_mux[`BP_MSB:`BP_LSB] = m_q.bp;
                rd_mux[`TB_BIT] = m_q.tb;
                rd_mux[`SEC_BIT] = m_q.sec;
                rd_mux[`CMP_BIT] = m_q.cmp;
            end
            `REG_DC: rd_mux[`DC_MSB:`DC_LSB] = m_q.dc;
            `REG_STAT: begin
                rd_mux[`STAT_PEND_BIT] = pending;
                rd_mux[`STAT_ANY_BIT] = m_q.any;
                rd_mux[`STAT_CMP_BIT] = m_q.cmp;
            end
            `REG_LO: rd_mux[22:0] = m_q.lo;
            `REG_HI: rd_mux[22:0] = m_q.hi;
            default: rd_mux = '0;
        endcase

        case (m_q.bst)
            bus_idle: begin
                // one wait state: the answer comes from flops
                if (avs_read || avs_write) begin
                    m_d.bst = bus_ack;
                    m_d.waitreq = 1'b0;
                    m_d.rdata = avs_read ? rd_mux : '0;
                    if (avs_write && avs_address == `REG_CFG) begin
                        // only the defined bits take the write
                        if (avs_byteenable[0]) begin
                            m_d.bp = avs_writedata[`BP_MSB:`BP_LSB];
                            m_d.tb = avs_writedata[`TB_BIT];
                            m_d.sec = avs_writedata[`SEC_BIT];
                        end
                        if (avs_byteenable[1]) begin
                            m_d.cmp = avs_writedata[`CMP_BIT];
                        end
                    end
                    if (avs_write && avs_address == `REG_DC &&
                        avs_byteenable[0]) begin
                        m_d.dc = avs_writedata[`DC_MSB:`DC_LSB];
                    end
                end
            end
            bus_ack: begin
                m_d.bst = bus_idle;
                m_d.waitreq = 1'b1;
            end
            default: begin
                m_d.bst = bus_idle;
                m_d.waitreq = 1'b1;
            end
        endcase

        // an empty level reads back as a zero range
        if (dec_any) begin
            m_d.lo = dec_lo;
            m_d.hi = dec_hi;
        end else begin
            m_d.lo = zero_addr;
            m_d.hi = zero_addr;
        end
        m_d.any = dec_any;

        live_word = {m_q.lo, m_q.hi, m_q.any, m_q.cmp, m_q.dc};
        sent_word = {m_q.sh_lo, m_q.sh_hi, m_q.sh_any, m_q.sh_cmp, m_q.sh_dc};
        // launch a new settings word once the link took the last one;
        // the shadow stays frozen while a toggle is in flight, so the
        // link side may copy it without a gray code
        if (!pending && (live_word != sent_word)) begin
            m_d.sh_lo = m_q.lo;
            m_d.sh_hi = m_q.hi;
            m_d.sh_any = m_q.any;
            m_d.sh_cmp = m_q.cmp;
            m_d.sh_dc = m_q.dc;
            m_d.req_tgl = ~m_q.req_tgl;
        end
        m_d.ack_meta = l_q.req_seen;
        m_d.ack_sync = m_q.ack_meta;

        if (!nrst) begin
            m_d = '0;
            m_d.bst = bus_idle;
            m_d.waitreq = 1'b1;
            m_d.bp = `BP_RST;
            m_d.tb = `TB_RST;
            m_d.sec = `SEC_RST;
            m_d.cmp = `CMP_RST;
            m_d.dc = `DC_RST;
        end
    end

    always_ff @(posedge mclk) begin
        m_q <= m_d;
    end

    // link side, on the host's serial clock
    logic [3:0] rd_count;
    logic pe_hit;

    // both use only settings already handed to this domain
    always_comb begin
        l_d = l_q;
        rd_count = dummy_for(rd_kind, rd_dtr, l_q.dc);
        pe_hit = region_hits(pe_lo, pe_hi, l_q.lo, l_q.hi, l_q.any,
                             l_q.cmp);
        // nrst comes from the mclk side: two flops first
        l_d.rst_n_meta = nrst;
        l_d.rst_n_sync = l_q.rst_n_meta;
        l_d.req_meta = m_q.req_tgl;
        l_d.req_sync = l_q.req_meta;
        l_d.pe_accept = 1'b0;
        l_d.pe_ignore = 1'b0;

        // shadow words are held still until this toggle is echoed
        if (l_q.req_sync != l_q.req_seen) begin
            l_d.lo = m_q.sh_lo;
            l_d.hi = m_q.sh_hi;
            l_d.any = m_q.sh_any;
            l_d.cmp = m_q.sh_cmp;
            l_d.dc = m_q.sh_dc;
            l_d.req_seen = l_q.req_sync;
        end

        if (link_cs_n) begin
            l_d.cnt = '0;
            l_d.data_phase = 1'b0;
        end else if (rd_start) begin
            l_d.cnt = rd_count;
            l_d.dummy = rd_count;
            l_d.data_phase = 1'b0;
        end else if (l_q.cnt != '0) begin
            l_d.cnt = l_q.cnt - 4'h1;
            if (l_q.cnt == 4'h1) begin
                l_d.data_phase = 1'b1;
            end
        end

        if (pe_req && !link_cs_n) begin
            if (pe_hit) begin
                l_d.pe_ignore = 1'b1;
            end else begin
                l_d.pe_accept = 1'b1;
            end
        end

        // this side leaves reset two serial clocks after nrst rises
        if (!l_q.rst_n_sync) begin
            l_d.req_meta = 1'b0;
            l_d.req_sync = 1'b0;
            l_d.req_seen = 1'b0;
            l_d.lo = '0;
            l_d.hi = '0;
            l_d.any = 1'b0;
            l_d.cmp = `CMP_RST;
            l_d.dc = `DC_RST;
            l_d.cnt = '0;
            l_d.data_phase = 1'b0;
            l_d.dummy = `DUMMY_8;
            l_d.pe_accept = 1'b0;
            l_d.pe_ignore = 1'b0;
        end
    end

    always_ff @(posedge link_clk) begin
        l_q <= l_d;
    end

    // outputs straight from flops
    assign avs_readdata = m_q.rdata;
    assign avs_waitrequest = m_q.waitreq;
    assign data_phase = l_q.data_phase;
    assign dummy_clocks = l_q.dummy;
    assign pe_accept = l_q.pe_accept;
    assign pe_ignore = l_q.pe_ignore;

endmodule // flash_prot
`default_nettype wire

// file: flash_prot_defs.svh
// constants for dummy clock selection and array protection
`ifndef FLASH_PROT_DEFS_SVH
`define FLASH_PROT_DEFS_SVH
// register byte addresses
`define REG_CFG 5'h00
`define REG_DC 5'h04
`define REG_STAT 5'h08
`define REG_LO 5'h0c
`define REG_HI 5'h10
// protect config and dummy clock select field positions
`define BP_LSB 2
`define BP_MSB 4
`define TB_BIT 5
`define SEC_BIT 6
`define CMP_BIT 14
`define DC_LSB 0
`define DC_MSB 1
// status field positions
`define STAT_PEND_BIT 0
`define STAT_ANY_BIT 1
`define STAT_CMP_BIT 2
// reset values
`define BP_RST 3'h0
`define TB_RST 1'h0
`define SEC_RST 1'h0
`define CMP_RST 1'h0
`define DC_RST 2'h0
// array geometry
`define ADDR_W 23
`define ARRAY_LAST 23'h7fffff
`define ARRAY_SIZE 24'h800000
`define BLOCK_SHIFT_BASE 5'h10
`define SECTOR_SHIFT_BASE 5'h0b
`define SECTOR_LEVEL_MAX 3'h4
`define BP_NONE 3'h0
`define BP_ALL 3'h7
// dummy clock counts
`define DUMMY_4 4'h4
`define DUMMY_6 4'h6
`define DUMMY_8 4'h8
`define DUMMY_10 4'ha
`define DC_00 2'h0
`define DC_01 2'h1
`define DC_10 2'h2
`define DC_11 2'h3
`endif

// file: flash_prot_pkg.sv
// types for dummy clock selection and array protection
`default_nettype none
package flash_prot_pkg;
    typedef enum logic [2:0] {
        rk_fast,
        rk_dual_out,
        rk_quad_out,
        rk_dual_io,
        rk_quad_word,
        rk_quad_io
    } read_kind_t;

    typedef enum logic {
        bus_idle,
        bus_ack
    } bus_state_t;

    typedef struct packed {
        bus_state_t bst;
        logic waitreq;
        logic [31:0] rdata;
        logic [2:0] bp;
        logic tb;
        logic sec;
        logic cmp;
        logic [1:0] dc;
        logic [22:0] lo;
        logic [22:0] hi;
        logic any;
        logic [22:0] sh_lo;
        logic [22:0] sh_hi;
        logic sh_any;
        logic sh_cmp;
        logic [1:0] sh_dc;
        logic req_tgl;
        logic ack_meta;
        logic ack_sync;
    } bus_regs_t;

    typedef struct packed {
        logic rst_n_meta;
        logic rst_n_sync;
        logic req_meta;
        logic req_sync;
        logic req_seen;
        logic [22:0] lo;
        logic [22:0] hi;
        logic any;
        logic cmp;
        logic [1:0] dc;
        logic [3:0] cnt;
        logic data_phase;
        logic [3:0] dummy;
        logic pe_accept;
        logic pe_ignore;
    } link_regs_t;
endpackage
`default_nettype wire

// file: flash_prot_properties.sv
// assertions on flash_prot ports
`default_nettype none
module flash_prot_properties (
    // system
    input wire logic mclk,
    input wire logic nrst,
    // bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // link
    input wire logic link_clk,
    input wire logic link_cs_n,
    input wire logic rd_start,
    input wire flash_prot_pkg::read_kind_t rd_kind,
    input wire logic rd_dtr,
    input wire logic pe_req,
    input wire logic data_phase,
    input wire logic [3:0] dummy_clocks,
    input wire logic pe_accept,
    input wire logic pe_ignore
);
    import flash_prot_pkg::*;
    sequence s_rd;
        rd_start && !link_cs_n;
    endsequence
    sequence s_pe;
        pe_req && !link_cs_n;
    endsequence
    AST_BUS_ANS: assert property (@(posedge mclk) disable iff (!nrst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered");
    AST_BUS_ONE: assert property (@(posedge mclk) disable iff (!nrst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer too long");
    AST_STR_8: assert property (@(posedge link_clk) disable iff (!nrst)
        s_rd ##0 (!rd_dtr && rd_kind inside {rk_fast, rk_dual_out,
        rk_quad_out}) |=> dummy_clocks == 4'h8)
        else $error("output read count not 8");
    AST_SEL_SET: assert property (@(posedge link_clk)
        disable iff (!nrst)
        s_rd |=> dummy_clocks inside {4'h4, 4'h6, 4'h8, 4'ha})
        else $error("illegal dummy count");
    AST_DATA_WAIT: assert property (@(posedge link_clk)
        disable iff (!nrst)
        s_rd |=> !data_phase [*3])
        else $error("data before dummy clocks");
    AST_DATA_CLR: assert property (@(posedge link_clk)
        disable iff (!nrst)
        link_cs_n |=> !data_phase)
        else $error("data phase outlives frame");
    AST_PE_ONE: assert property (@(posedge link_clk)
        disable iff (!nrst)
        s_pe |=> pe_accept != pe_ignore)
        else $error("region check not exactly one answer");
    AST_PE_QUIET: assert property (@(posedge link_clk)
        disable iff (!nrst)
        !(pe_req && !link_cs_n) |=> !(pe_accept || pe_ignore))
        else $error("region answer without request");
endmodule  // flash_prot_properties
bind flash_prot flash_prot_properties u_props (.*);
`default_nettype wire

// file: tb_flash_prot.sv
// self-checking bench for flash_prot
`default_nettype none
module tb_flash_prot;
    timeunit 1ns;
    timeprecision 100ps;
    import flash_prot_pkg::*;
    typedef struct packed {
        logic [15:0] cfg;
        logic [22:0] lo;
        logic [22:0] hi;
    } prot_case_t;
    logic mclk = 1'b0;
    logic nrst, avs_read, avs_write, avs_waitrequest;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable, dummy_clocks;
    logic link_clk, link_cs_n, rd_start, rd_dtr, pe_req;
    logic data_phase, pe_accept, pe_ignore;
    logic [22:0] pe_lo, pe_hi;
    read_kind_t rd_kind;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [3:0] tab_a [4] = '{4'h6, 4'h4, 4'h8, 4'ha};
    logic [3:0] tab_b [4] = '{4'h8, 4'h4, 4'h6, 4'ha};
    logic [3:0] tab_c [4] = '{4'h4, 4'h8, 4'h4, 4'h8};
    prot_case_t pc [8] = '{
        '{16'h0004, 23'h7e0000, 23'h7fffff},
        '{16'h0038, 23'h000000, 23'h3fffff},
        '{16'h004c, 23'h7fc000, 23'h7fffff},
        '{16'h0074, 23'h000000, 23'h007fff},
        '{16'h007c, 23'h000000, 23'h7fffff},
        '{16'h0020, 23'h000000, 23'h000000},
        '{16'h4008, 23'h7c0000, 23'h7fffff},
        '{16'h4000, 23'h000000, 23'h000000}};
    flash_prot u_dut (.*);
    flash_host_model u_host (.*);
    always #5 mclk = ~mclk;
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        @(posedge mclk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    function automatic logic [3:0] exp_dummy(input read_kind_t k,
                                             input logic d, input int s);
        if (d && (k == rk_fast || k == rk_dual_io)) return tab_a[s];
        if (d && k == rk_quad_io) return tab_b[s];
        if (k == rk_dual_io || k == rk_quad_word) return tab_c[s];
        if (k == rk_quad_io) return tab_a[s];
        return 4'h8;
    endfunction
    task automatic t_reset();
        logic [31:0] q;
        chk_word(32'(dummy_clocks), 32'h8);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 5'(i * 4), 32'h0, 4'hf, q);
            chk_word(q, 32'h0);
        end
        bus(1'b1, 5'h0c, 32'hffffffff, 4'hf, q);
        bus(1'b0, 5'h0c, 32'h0, 4'hf, q);
        chk_word(q, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_dummy();
        logic [31:0] q;
        logic [3:0] e;
        read_kind_t k;
        int n;
        for (int s = 0; s < 4; s++) begin
            // reserved bits set on purpose
            bus(1'b1, 5'h04, 32'hfffffffc | s, 4'hf, q);
            bus(1'b0, 5'h04, 32'h0, 4'hf, q);
            chk_word(q, 32'(s));
            u_host.settle();
            for (int i = 0; i < 12; i++) begin
                k = read_kind_t'(i / 2);
                e = exp_dummy(k, i[0], s);
                u_host.read_frame(k, i[0], n);
                chk_word(32'(n), 32'(e));
                chk_word(32'(dummy_clocks), 32'(e));
                u_host.close();
            end
        end
        $display("test dummy done");
    endtask
    task automatic t_protect();
        logic [31:0] q;
        logic [22:0] p;
        logic acc, ign, none, cmp, hit;
        prot_case_t c;
        foreach (pc[i]) begin
            c = pc[i];
            none = c.cfg[4:2] == 3'h0;
            cmp = c.cfg[14];
            bus(1'b1, 5'h00, {16'h0, c.cfg}, 4'hf, q);
            u_host.settle();
            bus(1'b0, 5'h08, 32'h0, 4'hf, q);
            chk_word(32'({q[2], q[0]}), 32'({cmp, 1'b0}));
            if (!cmp) begin
                bus(1'b0, 5'h0c, 32'h0, 4'hf, q);
                chk_word(q, 32'(c.lo));
                bus(1'b0, 5'h10, 32'h0, 4'hf, q);
                chk_word(q, 32'(c.hi));
            end
            u_host.pe_check(c.lo, c.lo, acc, ign);
            hit = !(none ^ cmp);
            chk_word(32'({acc, ign}), 32'({!hit, hit}));
            if (c.cfg[4:2] != 3'h7) begin
                p = c.lo == 23'h0 ? c.hi + 23'h1 : c.lo - 23'h1;
                u_host.pe_check(p, p, acc, ign);
                chk_word(32'({acc, ign}), 32'({!cmp, cmp}));
                u_host.pe_check(p < c.lo ? p : 23'h0, p < c.lo ? c.lo : p,
                                acc, ign);
                chk_word(32'(ign), 32'(!none || cmp));
            end
        end
        bus(1'b1, 5'h00, 32'h0000007c, 4'h2, q);
        bus(1'b0, 5'h00, 32'h0, 4'hf, q);
        chk_word(q, 32'h0);
        $display("test protect done");
    endtask
    initial begin
        nrst = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        fork
            repeat (6) @(posedge mclk);
            u_host.tick(5);
        join
        @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_dummy();
        t_protect();
        report_and_stop();
    end
endmodule  // tb_flash_prot
`default_nettype wire
